// File: core/cdf_pkg.sv
// Package: register map, field layout, encodings and timing for the clock dither monitor
package cdf_pkg;
  // Register bus
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_TRIM_A = 5'h04;
  localparam logic [4:0] OFF_TRIM_B = 5'h08;
  localparam logic [4:0] OFF_STAT = 5'h0C;
  localparam logic [4:0] OFF_MASK = 5'h10;
  // Control register fields
  localparam int CTRL_SWREQ = 0;
  localparam int CTRL_FAIL = 3;
  localparam int CTRL_SEQ_EN = 5;
  localparam int CTRL_DITH_EN = 6;
  localparam int CTRL_GRP_REQ = 8;
  localparam int CTRL_CURRENT_OSCILLATOR_FIELD_LO = 12;
  // Status and mask bits
  localparam int EV_W = 3;
  localparam int EV_FAIL = 0;
  localparam int EV_START = 1;
  localparam int EV_SWITCH = 2;
  // Trim layout
  localparam int TRIM_W = 4;
  localparam int SEQ_N = 8;
  localparam int LFSR_W = 15;
  localparam logic [14:0] LFSR_SEED = 15'h0001;
  localparam logic [15:0] TRIM_A_RST = 16'h0000;
  localparam logic [15:0] TRIM_B_RST = 16'h0000;
  // Current oscillator encodings
  localparam logic [2:0] CURRENT_OSCILLATOR_FIELD_FRC = 3'h0;
  // Monitor timing: no oscillator edge within this time is a failure
  localparam int CLK_NS = 40;
  localparam int MON_TIMEOUT_NS = 10000;
  localparam int MON_CYC = MON_TIMEOUT_NS / CLK_NS;
  // Switch/monitor select values
  localparam logic [1:0] FCK_BOTH_ON = 2'h0;
  typedef enum logic [1:0] {
    CK_INTERNAL = 2'b00,
    CK_PRIMARY = 2'b01
  } cdf_state_t;
  typedef struct packed {
    logic [1:0] switch_monitor_select;
    logic [1:0] new_oscillator_select;
    logic [1:0] primary_osc_mode;
  } cdf_cfg_t;
endpackage : cdf_pkg

// File: core/cdf_lfsr.sv
// Pseudo-random dither source: 15-bit maximal-length shift register
`timescale 1ns/1ps
module cdf_lfsr
  import cdf_pkg::*;
#(
  parameter int WIDTH = LFSR_W
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_step,
  output logic [WIDTH-1:0] o_value
);
  logic [WIDTH-1:0] lfsr_q;
  logic [WIDTH-1:0] lfsr_d;

  // Taps 15 and 14; nonzero seed keeps it out of the dead state
  always_comb begin
    lfsr_d = lfsr_q;
    if (i_step) begin
      lfsr_d = {lfsr_q[WIDTH-2:0], lfsr_q[WIDTH-1] ^ lfsr_q[WIDTH-2]};
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lfsr_q <= LFSR_SEED;
    end else begin
      lfsr_q <= lfsr_d;
    end
  end

  assign o_value = lfsr_q;
endmodule : cdf_lfsr

// File: core/cdf_monitor.sv
// Oscillator trim sequencer, pseudo-random dither and fail-safe clock monitor
// Behaviour
// - Sequence and dither off: trim from base field only
// - Eight-input 4-bit selector picks the trim
// - Selector index is cycle counter bits 5:3
// - Dither uses 15-bit XOR-feedback shift register
// - Dither trim is shift register low nibble
// - Dither runs only while enabled
// - Shift register steps when counter bit 3 toggles
// - Select field 1x disables switching and monitor
// - Failure traps and moves to internal RC
// - Failure loads RC code, sets fail, clears request
// - Failure leaves watchdog clock untouched
// - Start-up timeout traps and stops starting oscillator
// - Switch only between groups; primary follows config
// - Switching off: config selects, field only reports
// - Trim comes from trim register a or b, or from the shift register while dither is on
`timescale 1ns/1ps
module cdf_monitor
  import cdf_pkg::*;
#(
  parameter int MON_CYCLES = MON_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire cdf_cfg_t i_cfg,
  input wire logic [5:0] i_roll_count,
  input wire logic i_power_up_timer_expired,
  input wire logic i_osc_tick,
  input wire logic i_osc_ready,
  output logic [TRIM_W-1:0] o_trim,
  output logic [2:0] o_current_osc,
  output logic [1:0] o_primary_mode,
  output logic o_primary_osc_enable,
  output logic o_wdt_clock_enable,
  output logic o_fail_trap,
  output logic o_irq
);
  // Software-visible state
  logic seq_en_q, seq_en_d;
  logic dith_en_q, dith_en_d;
  logic swreq_q, swreq_d;
  logic grp_req_q, grp_req_d;
  logic fail_q, fail_d;
  logic [2:0] current_oscillator_field_q, current_oscillator_field_d;
  logic [15:0] trim_a_q, trim_a_d;
  logic [15:0] trim_b_q, trim_b_d;
  logic [EV_W-1:0] stat_q, stat_d;
  logic [EV_W-1:0] mask_q, mask_d;
  logic [15:0] rdata_q, rdata_d;
  // Clock control state
  cdf_state_t state_q, state_d;
  logic init_q, init_d;
  logic trap_q, trap_d;
  logic [15:0] mon_cnt_q, mon_cnt_d;
  // Pin synchronisers and filtered levels
  logic [1:0] sync1_q, sync2_q, sync3_q;
  logic tick_lvl_q, tick_lvl_d;
  logic ready_lvl_q, ready_lvl_d;
  // Trim path
  logic roll3_q;
  logic [TRIM_W-1:0] trim_q, trim_d;
  logic [LFSR_W-1:0] lfsr_val;
  logic lfsr_step;
  logic [TRIM_W-1:0] seq_tbl [SEQ_N];
  logic [EV_W-1:0] ev;
  logic sw_en, mon_en, tick_ev;

  // Selector inputs: index zero is the base field
  genvar gi;
  generate
    for (gi = 0; gi < SEQ_N; gi++) begin : g_tbl
      if (gi < 4) begin : g_a
        assign seq_tbl[gi] = trim_a_q[gi*TRIM_W +: TRIM_W];
      end else begin : g_b
        assign seq_tbl[gi] = trim_b_q[(gi-4)*TRIM_W +: TRIM_W];
      end
    end
  endgenerate

  // Field 1x turns off both switching and the monitor
  assign sw_en = ~i_cfg.switch_monitor_select[1];
  assign mon_en = (i_cfg.switch_monitor_select == FCK_BOTH_ON);

  // Counter bit 3 flips once per eight PWM rollovers
  assign lfsr_step = dith_en_q & (i_roll_count[3] ^ roll3_q);

  cdf_lfsr #(
    .WIDTH(LFSR_W)
  ) u_lfsr (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_step(lfsr_step),
    .o_value(lfsr_val)
  );

  // Trim source: dither first, then sequence, else base
  always_comb begin
    trim_d = trim_a_q[TRIM_W-1:0];
    if (dith_en_q) begin
      trim_d = lfsr_val[TRIM_W-1:0];
    end else if (seq_en_q) begin
      trim_d = seq_tbl[i_roll_count[5:3]];
    end
  end

  // Three-stage sync; a change counts when stages two and three agree
  always_comb begin
    tick_lvl_d = tick_lvl_q;
    ready_lvl_d = ready_lvl_q;
    if (sync2_q[0] == sync3_q[0]) begin
      tick_lvl_d = sync3_q[0];
    end
    if (sync2_q[1] == sync3_q[1]) begin
      ready_lvl_d = sync3_q[1];
    end
  end
  assign tick_ev = tick_lvl_d ^ tick_lvl_q;

  // Clock group control, monitor and software registers
  always_comb begin
    state_d = state_q;
    current_oscillator_field_d = current_oscillator_field_q;
    init_d = 1'b1;
    trap_d = 1'b0;
    mon_cnt_d = mon_cnt_q;
    seq_en_d = seq_en_q;
    dith_en_d = dith_en_q;
    swreq_d = swreq_q;
    grp_req_d = grp_req_q;
    fail_d = fail_q;
    trim_a_d = trim_a_q;
    trim_b_d = trim_b_q;
    mask_d = mask_q;
    ev = '0;
    // Software writes
    if (i_wr) begin
      case (i_addr)
        OFF_CTRL: begin
          seq_en_d = i_wdata[CTRL_SEQ_EN];
          dith_en_d = i_wdata[CTRL_DITH_EN];
          grp_req_d = i_wdata[CTRL_GRP_REQ];
          swreq_d = i_wdata[CTRL_SWREQ];
          fail_d = fail_q & i_wdata[CTRL_FAIL];
        end
        OFF_TRIM_A: trim_a_d = i_wdata;
        OFF_TRIM_B: trim_b_d = i_wdata;
        OFF_MASK: mask_d = i_wdata[EV_W-1:0];
        default: ;
      endcase
    end
    // Monitor counts cycles since the last oscillator edge
    if (tick_ev || state_q != CK_PRIMARY) begin
      mon_cnt_d = '0;
    end else if (mon_cnt_q != 16'hFFFF) begin
      mon_cnt_d = mon_cnt_q + 16'h0001;
    end
    if (!sw_en || !init_q) begin
      // Config straps pick the oscillator; field only reports
      current_oscillator_field_d = {i_cfg.new_oscillator_select[1], i_cfg.new_oscillator_select};
      state_d = i_cfg.new_oscillator_select[1] ? CK_PRIMARY : CK_INTERNAL;
    end
    if (init_q) begin
      case (state_q)
        CK_PRIMARY: begin
          if (mon_en && i_power_up_timer_expired && !ready_lvl_q) begin
            // Oscillator still starting: abandon it
            ev[EV_START] = 1'b1;
          end else if (mon_en && mon_cnt_q >= MON_CYCLES[15:0]) begin
            ev[EV_FAIL] = 1'b1;
          end else if (sw_en && swreq_q && !grp_req_q) begin
            state_d = CK_INTERNAL;
            current_oscillator_field_d = CURRENT_OSCILLATOR_FIELD_FRC;
            swreq_d = 1'b0;
            ev[EV_SWITCH] = 1'b1;
          end
          if (ev[EV_START] || ev[EV_FAIL]) begin
            state_d = CK_INTERNAL;
            current_oscillator_field_d = CURRENT_OSCILLATOR_FIELD_FRC;
            fail_d = 1'b1;
            swreq_d = 1'b0;
            trap_d = 1'b1;
          end
        end
        CK_INTERNAL: begin
          if (sw_en && swreq_q && grp_req_q) begin
            // Within the primary group the straps decide
            state_d = CK_PRIMARY;
            current_oscillator_field_d = {1'b1, i_cfg.new_oscillator_select};
            swreq_d = 1'b0;
            ev[EV_SWITCH] = 1'b1;
          end
        end
        default: begin
          state_d = CK_INTERNAL;
          current_oscillator_field_d = CURRENT_OSCILLATOR_FIELD_FRC;
        end
      endcase
    end
    // Sticky status: a new event wins over a write-one clear
    stat_d = stat_q;
    if (i_wr && i_addr == OFF_STAT) begin
      stat_d = stat_q & ~i_wdata[EV_W-1:0];
    end
    stat_d = stat_d | ev;
  end

  // Read data stands in the cycle after the strobe
  always_comb begin
    rdata_d = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        OFF_CTRL: begin
          rdata_d[CTRL_CURRENT_OSCILLATOR_FIELD_LO +: 3] = current_oscillator_field_q;
          rdata_d[CTRL_GRP_REQ] = grp_req_q;
          rdata_d[CTRL_DITH_EN] = dith_en_q;
          rdata_d[CTRL_SEQ_EN] = seq_en_q;
          rdata_d[CTRL_FAIL] = fail_q;
          rdata_d[CTRL_SWREQ] = swreq_q;
        end
        OFF_TRIM_A: rdata_d = trim_a_q;
        OFF_TRIM_B: rdata_d = trim_b_q;
        OFF_STAT: rdata_d[EV_W-1:0] = stat_q;
        OFF_MASK: rdata_d[EV_W-1:0] = mask_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q <= CK_INTERNAL;
      current_oscillator_field_q <= CURRENT_OSCILLATOR_FIELD_FRC;
      init_q <= 1'b0;
      trap_q <= 1'b0;
      mon_cnt_q <= 16'h0000;
      seq_en_q <= 1'b0;
      dith_en_q <= 1'b0;
      swreq_q <= 1'b0;
      grp_req_q <= 1'b0;
      fail_q <= 1'b0;
      trim_a_q <= TRIM_A_RST;
      trim_b_q <= TRIM_B_RST;
      stat_q <= '0;
      mask_q <= '0;
      rdata_q <= 16'h0000;
      trim_q <= 4'h0;
      roll3_q <= 1'b0;
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      sync3_q <= 2'h0;
      tick_lvl_q <= 1'b0;
      ready_lvl_q <= 1'b0;
    end else begin
      state_q <= state_d;
      current_oscillator_field_q <= current_oscillator_field_d;
      init_q <= init_d;
      trap_q <= trap_d;
      mon_cnt_q <= mon_cnt_d;
      seq_en_q <= seq_en_d;
      dith_en_q <= dith_en_d;
      swreq_q <= swreq_d;
      grp_req_q <= grp_req_d;
      fail_q <= fail_d;
      trim_a_q <= trim_a_d;
      trim_b_q <= trim_b_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      trim_q <= trim_d;
      roll3_q <= i_roll_count[3];
      sync1_q <= {i_osc_ready, i_osc_tick};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      tick_lvl_q <= tick_lvl_d;
      ready_lvl_q <= ready_lvl_d;
    end
  end

  // Outputs; watchdog runs on its own RC whatever happens here
  assign o_wdt_clock_enable = 1'b1;
  assign o_rdata = rdata_q;
  assign o_trim = trim_q;
  assign o_current_osc = current_oscillator_field_q;
  assign o_primary_mode = i_cfg.primary_osc_mode;
  assign o_primary_osc_enable = (state_q == CK_PRIMARY);
  assign o_fail_trap = trap_q;
  assign o_irq = |(stat_q & mask_q);

  // Checks
  AST_BASE_ONLY: assert property (@(posedge i_clock) disable iff (i_rst)
    !dith_en_q && !seq_en_q |=> o_trim == $past(trim_a_q[3:0]))
    else $error("trim not from base field");
  AST_SEQ_SEL: assert property (@(posedge i_clock) disable iff (i_rst)
    !dith_en_q && seq_en_q && i_roll_count[5:3] == 3'h0 |=> o_trim == $past(trim_a_q[3:0]))
    else $error("index zero did not pick base");
  AST_SEQ_TOP: assert property (@(posedge i_clock) disable iff (i_rst)
    !dith_en_q && seq_en_q && i_roll_count[5:3] == 3'h7 |=> o_trim == $past(trim_b_q[15:12]))
    else $error("index seven wrong entry");
  AST_DITHER: assert property (@(posedge i_clock) disable iff (i_rst)
    dith_en_q |=> o_trim == $past(lfsr_val[3:0]))
    else $error("dither trim not lfsr nibble");
  AST_LFSR_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
    !dith_en_q || i_roll_count[3] == roll3_q |=> $stable(lfsr_val))
    else $error("lfsr stepped without toggle");
  AST_NO_MON: assert property (@(posedge i_clock) disable iff (i_rst)
    i_cfg.switch_monitor_select[1] |-> !trap_d)
    else $error("trap with monitor disabled");
  AST_FAIL: assert property (@(posedge i_clock) disable iff (i_rst)
    trap_d |=> current_oscillator_field_q == CURRENT_OSCILLATOR_FIELD_FRC && fail_q && !swreq_q && o_fail_trap && !o_primary_osc_enable)
    else $error("failure handling incomplete");
  AST_TIMEOUT: assert property (@(posedge i_clock) disable iff (i_rst)
    init_q && state_q == CK_PRIMARY && mon_en && mon_cnt_q >= MON_CYCLES[15:0] |=> trap_q)
    else $error("missed oscillator failure");
  AST_STRAPS: assert property (@(posedge i_clock) disable iff (i_rst)
    !sw_en |=> current_oscillator_field_q == {$past(i_cfg.new_oscillator_select[1]), $past(i_cfg.new_oscillator_select)})
    else $error("field not following straps");
endmodule : cdf_monitor

// File: verification/cdf_pwm_model.sv
// Partner model: PWM primary time base and its rollover counter
`timescale 1ns/1ps
module cdf_pwm_model #(
  parameter int PERIOD = 3
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_run,
  output logic [5:0] o_roll_count
);
  logic [7:0] base_q;
  // Period counter; clearing i_run stalls the time base
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      base_q <= 8'h00;
      o_roll_count <= 6'h00;
    end else if (i_run) begin
      if (base_q == 8'(PERIOD - 1)) begin
        base_q <= 8'h00;
        o_roll_count <= o_roll_count + 6'h01;
      end else begin
        base_q <= base_q + 8'h01;
      end
    end
  end
endmodule : cdf_pwm_model

// File: verification/test_clock_dither_failsafe_monitor.sv
// Testbench: trim sequencing, dither and fail-safe monitor
`timescale 1ns/1ps
module test_clock_dither_failsafe_monitor
  import cdf_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  cdf_cfg_t i_cfg = '{2'h2, 2'h2, 2'h2};
  logic power_up_timer = 1'b1;
  logic tick = 1'b0;
  logic tdiv = 1'b0;
  logic tick_run = 1'b0;
  logic ready = 1'b0;
  logic run = 1'b1;
  logic [5:0] roll;
  logic [15:0] o_rdata;
  logic [3:0] trim;
  logic [2:0] current_oscillator_field;
  logic [1:0] pmode;
  logic pen, wdt, trap, irq;
  logic [15:0] rd_val;
  logic [14:0] lfsr;
  int mismatches = 0;
  int num_checks = 0;
  int traps = 0;

  always #20 i_clock = ~i_clock;

  cdf_pwm_model #(.PERIOD(3)) cdf_pwm_model_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_run(run), .o_roll_count(roll));

  // Short monitor window keeps the failure scenarios quick
  cdf_monitor #(.MON_CYCLES(8)) cdf_monitor_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cfg(i_cfg), .i_roll_count(roll), .i_power_up_timer_expired(power_up_timer), .i_osc_tick(tick),
    .i_osc_ready(ready), .o_trim(trim), .o_current_osc(current_oscillator_field), .o_primary_mode(pmode),
    .o_primary_osc_enable(pen), .o_wdt_clock_enable(wdt), .o_fail_trap(trap), .o_irq(irq));

  // Monitored oscillator: edge every two cycles, far above the floor
  always @(posedge i_clock) begin
    if (tick_run) begin
      tdiv <= ~tdiv;
      if (tdiv) tick <= ~tick;
    end
    if (trap === 1'b1) traps <= traps + 1;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : cyc

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask : rd

  // Bounded waits; running out counts as a mismatch
  task automatic wait_for(input int kind, input int arg);
    int t0;
    int n;
    logic b;
    t0 = traps;
    b = roll[3];
    n = 0;
    while (n < 300 && ((kind == 0 && traps == t0) || (kind == 1 && roll[3] === b)
           || (kind == 2 && int'(roll[5:3]) != arg))) begin
      cyc(1);
      n++;
    end
    if (n == 300) begin
      mismatches++;
      $display("wrong value at %0t: wait %0d timed out", $time, kind);
      give_verdict();
    end
  endtask : wait_for

  task automatic do_reset(input cdf_cfg_t c);
    @(posedge i_clock);
    i_rst <= 1'b1;
    i_cfg <= c;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
  endtask : do_reset

  initial begin
    // Monitor off by straps: no trap even with a dead oscillator
    do_reset('{2'h2, 2'h2, 2'h2});
    cyc(2);
    check(16'(current_oscillator_field), 16'h0006, "strap osc");
    check(16'(pmode), 16'h0002, "mode");
    check(16'(wdt), 16'h0001, "wdt");
    cyc(60);
    check(16'(traps), 16'h0000, "disabled trap");
    wr(OFF_TRIM_A, 16'h4321);
    wr(OFF_TRIM_B, 16'h8765);
    rd(OFF_TRIM_A);
    check(rd_val, 16'h4321, "trim a");
    rd(5'h14);
    check(rd_val, 16'h0000, "unmapped");
    wait_for(2, 3);
    cyc(2);
    check(16'(trim), 16'h0001, "base only");
    // Sequence: nibbles 1..8 by counter bits 5:3
    wr(OFF_CTRL, 16'h0020);
    for (int i = 0; i < 8; i++) begin
      wait_for(2, i);
      cyc(2);
      check(16'(trim), 16'(i + 1), "seq");
    end
    // Dither on top of sequence, time base held while enabling
    run <= 1'b0;
    cyc(2);
    wr(OFF_CTRL, 16'h0060);
    cyc(3);
    lfsr = 15'h0001;
    check(16'(trim), 16'h0001, "seed");
    run <= 1'b1;
    // Enough steps for the top taps to feed back into the low nibble
    for (int k = 0; k < 18; k++) begin
      wait_for(1, 0);
      cyc(4);
      lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
      check(16'(trim), 16'(lfsr[3:0]), "dither");
    end
    run <= 1'b0;
    cyc(1);
    wr(OFF_CTRL, 16'h0020);
    cyc(3);
    check(16'(trim), 16'(roll[5:3]) + 16'h0001, "dither off");
    run <= 1'b1;
    // Monitor on, primary group; timer held until sync settles
    power_up_timer <= 1'b0;
    tick_run <= 1'b1;
    ready <= 1'b1;
    do_reset('{FCK_BOTH_ON, 2'h2, 2'h2});
    cyc(10);
    power_up_timer <= 1'b1;
    cyc(20);
    check(16'(traps), 16'h0000, "healthy osc");
    check(16'(pen), 16'h0001, "primary");
    tick_run <= 1'b0;
    wait_for(0, 0);
    cyc(1);
    check(16'(current_oscillator_field), 16'(CURRENT_OSCILLATOR_FIELD_FRC), "fail osc");
    check(16'(pen), 16'h0000, "fail stop");
    check(16'(irq), 16'h0000, "masked irq");
    rd(OFF_CTRL);
    check(rd_val & 16'h7009, 16'h0008, "fail ctrl");
    wr(OFF_MASK, 16'h0001);
    cyc(1);
    check(16'(irq), 16'h0001, "irq");
    wr(OFF_STAT, 16'h0001);
    cyc(1);
    check(16'(irq), 16'h0000, "irq clear");
    // Back to primary group by software request
    tick_run <= 1'b1;
    cyc(4);
    wr(OFF_CTRL, 16'h0101);
    cyc(3);
    check(16'(current_oscillator_field), 16'h0006, "switch osc");
    rd(OFF_CTRL);
    check(rd_val & 16'h7009, 16'h6000, "switch ctrl");
    rd(OFF_STAT);
    check(rd_val & 16'h0005, 16'h0004, "switch stat");
    // Software move to the internal group, then back to primary
    wr(OFF_CTRL, 16'h0001);
    cyc(3);
    check(16'(current_oscillator_field), 16'(CURRENT_OSCILLATOR_FIELD_FRC), "switch rc");
    check(16'(pen), 16'h0000, "switch rc stop");
    wr(OFF_CTRL, 16'h0101);
    cyc(3);
    check(16'(pen), 16'h0001, "switch back");
    // Oscillator not ready after power-up timer
    ready <= 1'b0;
    wait_for(0, 0);
    cyc(1);
    check(16'(pen), 16'h0000, "startup stop");
    check(16'(current_oscillator_field), 16'(CURRENT_OSCILLATOR_FIELD_FRC), "startup osc");
    rd(OFF_STAT);
    check(rd_val & 16'h0002, 16'h0002, "startup stat");
    give_verdict();
  end
endmodule : test_clock_dither_failsafe_monitor
